//--- flash_ctrl_pkg.sv
// Constants, register map and bus carrier for the flash program/erase control.
// Assumes an 8-bit CPU peripheral bus with a 16-bit byte address.
`default_nettype none

package flash_ctrl_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [15:0] MODE_CONTROL_ADDR = 16'hF020;
   localparam logic [15:0] FAULT_STATUS_ADDR = 16'hF021;
   localparam logic [15:0] POWER_CONTROL_ADDR = 16'hF022;
   localparam logic [15:0] ERASE_SELECT_ADDR = 16'hF023;
   localparam logic [15:0] REGISTER_GATE_ADDR = 16'hF02B;

   localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
   localparam logic [7:0] FAULT_STATUS_RESET = 8'h00;
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] ERASE_SELECT_RESET = 8'h00;
   localparam logic [7:0] REGISTER_GATE_RESET = 8'h00;
   // Read data for variants built without flash
   localparam logic [7:0] ABSENT_READ_VALUE = 8'hFF;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int WRITE_UNLOCK_BIT = 6;
   localparam int ERASE_PREP_BIT = 5;
   localparam int PROGRAM_PREP_BIT = 4;
   localparam int ERASE_CHECK_BIT = 3;
   localparam int PROGRAM_CHECK_BIT = 2;
   localparam int ERASE_GO_BIT = 1;
   localparam int PROGRAM_GO_BIT = 0;
   localparam int FAULT_BIT = 7;
   localparam int POWERDOWN_INHIBIT_BIT = 7;
   localparam int ACCESS_ENABLE_BIT = 7;
   localparam int ERASE_BLOCKS = 5;

   // ************************************************************
   // Array layout
   // ************************************************************
   localparam int ARRAY_ADDR_W = 15;
   localparam int UNIT_OFFSET_W = 7;
   localparam logic [15:0] ARRAY_LIMIT = 16'h8000;
   localparam logic [14:0] BLOCK1_BASE = 15'h0400;
   localparam logic [14:0] BLOCK2_BASE = 15'h0800;
   localparam logic [14:0] BLOCK3_BASE = 15'h0C00;
   localparam logic [14:0] BLOCK4_BASE = 15'h1000;

   typedef struct packed {
      logic sel;
      logic wr;
      logic byte_acc;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cpu_req_s;

endpackage : flash_ctrl_pkg

`default_nettype wire

//--- flash_ctrl.sv
// Flash program/erase control: five byte-wide control registers, mode
// sequencing, erase block selection, program unit capture and power-down.
// Assumes a two-state CPU bus on the same clock; the array itself and its
// pulse timing live outside and follow the mode outputs.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RL1: Programming works on 128-byte units starting at low address byte 00 or 80.
// RL2: Erase covers whole blocks only: four 1-kbyte blocks and one 28-kbyte block.
// RL3: Software erases the whole array block by block, one after another.
// RL4: In user program mode blocks are erased or programmed selectively.
// RL5: Only byte accesses reach the control registers, each in two bus states.
// RL6: Without flash fitted, register reads are undefined and writes ignored.
// RL7: Mode control selects program, program-verify, erase, erase-verify; resets zero.
// RL8: Software keeps mode bits 6..0 clear when reading the array as ROM.
// RL9: Mode control bit 7 reads zero and ignores writes.
// RL10: With write_unlock clear, no other mode bit or block select bit sets.
// RL11: Software sets write_unlock before mode bits 5..0 or block selects.
// RL12: Software sets erase_prep before erase_go.
// RL13: Software sets each mode bit in its own register write.
// RL14: Subactive with power-down allowed partly halts supply, array still readable.
// RL15: erase_go takes effect only while write_unlock and erase_prep are set; code checks the prior erase_prep, so erase_go can outlive it.
// RL16: program_go takes effect only while write_unlock and program_prep are set; code checks the prior program_prep, so program_go can outlive it.
// RL17: Block select is zero while locked; several bits at once clear all.
// RL18: With ctrl_access_enable clear, the four control registers are blocked.
// RL19: With no mode bit set, array reads are served as plain ROM.
module flash_ctrl
   import flash_ctrl_pkg::*;
#(
   parameter bit FLASH_FITTED = 1'b1
) (
   input wire logic clock,
   input wire logic resetn,
   input wire cpu_req_s cpu_req,
   input wire logic subactive,
   input wire logic fault_detect,
   output logic cpu_ack,
   output logic [7:0] cpu_rdata,
   output logic rom_read_en,
   output logic [6:0] mode_bits,
   output logic [ERASE_BLOCKS-1:0] block_erase,
   output logic power_down,
   output logic unit_write,
   output logic [ARRAY_ADDR_W-1:0] unit_base,
   output logic [UNIT_OFFSET_W-1:0] unit_offset,
   output logic [7:0] unit_data,
   output logic [2:0] access_block
);

   // ************************************************************
   // Block map
   // ************************************************************
   function automatic logic [2:0] block_of(input logic [14:0] a);
      logic [2:0] b;
      b = 3'h4;
      if (a < BLOCK1_BASE) begin
         b = 3'h0;
      end else if (a < BLOCK2_BASE) begin
         b = 3'h1;
      end else if (a < BLOCK3_BASE) begin
         b = 3'h2;
      end else if (a < BLOCK4_BASE) begin
         b = 3'h3;
      end
      return b;
   endfunction

   logic [7:0] mode_q, mode_d;
   logic [7:0] fault_q, fault_d;
   logic [7:0] power_q, power_d;
   logic [7:0] select_q, select_d;
   logic [7:0] gate_q, gate_d;
   logic ack_q, ack_d;
   logic [7:0] rdata_q, rdata_d;
   logic rom_q, rom_d;
   logic [ERASE_BLOCKS-1:0] erase_q, erase_d;
   logic pdown_q, pdown_d;
   logic uwr_q, uwr_d;
   logic [ARRAY_ADDR_W-1:0] ubase_q, ubase_d;
   logic [UNIT_OFFSET_W-1:0] uoff_q, uoff_d;
   logic [7:0] udata_q, udata_d;
   logic [2:0] blk_q, blk_d;

   logic take, reg_wr, gated, unlocked;
   logic hit_mode, hit_fault, hit_power, hit_select, hit_gate;
   logic array_hit, reg_space;

   // ************************************************************
   // Bus decode
   // ************************************************************
   always_comb begin
      take = cpu_req.sel & ~ack_q;
      // RL5 byte only
      reg_wr = take & cpu_req.wr & cpu_req.byte_acc & FLASH_FITTED;
      // RL18 access gate
      gated = gate_q[ACCESS_ENABLE_BIT];
      hit_mode = gated & (cpu_req.addr == MODE_CONTROL_ADDR);
      hit_fault = gated & (cpu_req.addr == FAULT_STATUS_ADDR);
      hit_power = gated & (cpu_req.addr == POWER_CONTROL_ADDR);
      hit_select = gated & (cpu_req.addr == ERASE_SELECT_ADDR);
      hit_gate = cpu_req.addr == REGISTER_GATE_ADDR;
      array_hit = cpu_req.addr < ARRAY_LIMIT;
      // Raw register window, independent of the access gate
      reg_space = (cpu_req.addr >= MODE_CONTROL_ADDR) & (cpu_req.addr <= ERASE_SELECT_ADDR)
         | hit_gate;
      unlocked = mode_q[WRITE_UNLOCK_BIT];
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   always_comb begin
      mode_d = mode_q;
      fault_d = fault_q;
      power_d = power_q;
      select_d = select_q;
      gate_d = gate_q;
      if (reg_wr & hit_mode) begin
         mode_d = 8'h00;
         mode_d[WRITE_UNLOCK_BIT] = cpu_req.wdata[WRITE_UNLOCK_BIT];
         // RL10 locked bits
         if (unlocked & cpu_req.wdata[WRITE_UNLOCK_BIT]) begin
            mode_d[ERASE_PREP_BIT] = cpu_req.wdata[ERASE_PREP_BIT];
            mode_d[PROGRAM_PREP_BIT] = cpu_req.wdata[PROGRAM_PREP_BIT];
            mode_d[ERASE_CHECK_BIT] = cpu_req.wdata[ERASE_CHECK_BIT];
            mode_d[PROGRAM_CHECK_BIT] = cpu_req.wdata[PROGRAM_CHECK_BIT];
            // RL15 erase entry
            mode_d[ERASE_GO_BIT] = cpu_req.wdata[ERASE_GO_BIT]
               & mode_q[ERASE_PREP_BIT];
            // RL16 program entry
            mode_d[PROGRAM_GO_BIT] = cpu_req.wdata[PROGRAM_GO_BIT]
               & mode_q[PROGRAM_PREP_BIT];
         end
      end
      // RL9 reserved top bit
      mode_d[7] = 1'b0;
      if (reg_wr & hit_power) begin
         power_d = 8'h00;
         power_d[POWERDOWN_INHIBIT_BIT] = cpu_req.wdata[POWERDOWN_INHIBIT_BIT];
      end
      if (reg_wr & hit_select) begin
         select_d = {3'h0, cpu_req.wdata[ERASE_BLOCKS-1:0]};
         // RL17 multiple select
         if ($countones(cpu_req.wdata[ERASE_BLOCKS-1:0]) > 1) begin
            select_d = 8'h00;
         end
      end
      // RL17 locked select
      if (~mode_d[WRITE_UNLOCK_BIT]) begin
         select_d = 8'h00;
      end
      if (reg_wr & hit_gate) begin
         gate_d = 8'h00;
         gate_d[ACCESS_ENABLE_BIT] = cpu_req.wdata[ACCESS_ENABLE_BIT];
      end
      // Fault is sticky until reset; only the error-protection logic sets it
      if (fault_detect & (mode_q[ERASE_GO_BIT] | mode_q[PROGRAM_GO_BIT])) begin
         fault_d[FAULT_BIT] = 1'b1;
      end
   end

   // ************************************************************
   // Read path and two-state answer
   // ************************************************************
   always_comb begin
      ack_d = take;
      rdata_d = 8'h00;
      if (take & ~cpu_req.wr & cpu_req.byte_acc) begin
         if (hit_mode) begin
            rdata_d = mode_q;
         end else if (hit_fault) begin
            rdata_d = fault_q;
         end else if (hit_power) begin
            rdata_d = power_q;
         end else if (hit_select) begin
            rdata_d = select_q;
         end else if (hit_gate) begin
            rdata_d = gate_q;
         end
         // RL6 no flash fitted
         // The gate never opens on such a variant, so decode the raw window
         if (!FLASH_FITTED & reg_space) begin
            rdata_d = ABSENT_READ_VALUE;
         end
      end
   end

   // ************************************************************
   // Array side: ROM reads, program units, erase, power-down
   // ************************************************************
   always_comb begin
      // RL19 plain ROM
      rom_d = mode_q[6:0] == 7'h00;
      // RL2 whole block erase
      erase_d = select_q[ERASE_BLOCKS-1:0]
         & {ERASE_BLOCKS{mode_q[ERASE_GO_BIT] & ~fault_q[FAULT_BIT]}};
      // RL14 power-down
      pdown_d = subactive & ~power_q[POWERDOWN_INHIBIT_BIT];
      uwr_d = 1'b0;
      ubase_d = ubase_q;
      uoff_d = uoff_q;
      udata_d = udata_q;
      blk_d = blk_q;
      if (take & array_hit) begin
         // RL4 per block
         blk_d = block_of(cpu_req.addr[ARRAY_ADDR_W-1:0]);
      end
      // Writes to the array only matter once program setup is armed
      if (take & cpu_req.wr & array_hit & unlocked
            & mode_q[PROGRAM_PREP_BIT]) begin
         uwr_d = 1'b1;
         // RL1 unit alignment
         ubase_d = {cpu_req.addr[ARRAY_ADDR_W-1:UNIT_OFFSET_W],
            {UNIT_OFFSET_W{1'b0}}};
         uoff_d = cpu_req.addr[UNIT_OFFSET_W-1:0];
         udata_d = cpu_req.wdata;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         // RL7 reset value
         mode_q <= MODE_CONTROL_RESET;
         fault_q <= FAULT_STATUS_RESET;
         power_q <= POWER_CONTROL_RESET;
         select_q <= ERASE_SELECT_RESET;
         gate_q <= REGISTER_GATE_RESET;
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
         rom_q <= 1'b1;
         erase_q <= '0;
         pdown_q <= 1'b0;
         uwr_q <= 1'b0;
         ubase_q <= '0;
         uoff_q <= '0;
         udata_q <= 8'h00;
         blk_q <= 3'h0;
      end else begin
         mode_q <= mode_d;
         fault_q <= fault_d;
         power_q <= power_d;
         select_q <= select_d;
         gate_q <= gate_d;
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         rom_q <= rom_d;
         erase_q <= erase_d;
         pdown_q <= pdown_d;
         uwr_q <= uwr_d;
         ubase_q <= ubase_d;
         uoff_q <= uoff_d;
         udata_q <= udata_d;
         blk_q <= blk_d;
      end
   end

   assign cpu_ack = ack_q;
   assign cpu_rdata = rdata_q;
   assign rom_read_en = rom_q;
   assign mode_bits = mode_q[6:0];
   assign block_erase = erase_q;
   assign power_down = pdown_q;
   assign unit_write = uwr_q;
   assign unit_base = ubase_q;
   assign unit_offset = uoff_q;
   assign unit_data = udata_q;
   assign access_block = blk_q;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   a_reserved_bit_zero: assert property (mode_q[7] == 1'b0) // RL9
      else $error("mode control bit 7 set");
   a_locked_bits_clear: assert property (
      !mode_q[WRITE_UNLOCK_BIT] |-> (mode_q[5:0] == 6'h00)) // RL10
      else $error("mode bit set while locked");
   a_erase_needs_prep: assert property (
      $rose(mode_q[ERASE_GO_BIT]) |-> $past(mode_q[ERASE_PREP_BIT])
      && $past(mode_q[WRITE_UNLOCK_BIT])) // RL15
      else $error("erase entered without prep");
   a_program_needs_prep: assert property (
      $rose(mode_q[PROGRAM_GO_BIT]) |-> $past(mode_q[PROGRAM_PREP_BIT])
      && $past(mode_q[WRITE_UNLOCK_BIT])) // RL16
      else $error("program entered without prep");
   a_select_onehot: assert property (
      $countones(select_q) <= 1 && (select_q == 8'h00
      || mode_q[WRITE_UNLOCK_BIT])) // RL17
      else $error("block select invalid");
   a_two_state_ack: assert property (
      take |=> cpu_ack ##1 !cpu_ack) // RL5
      else $error("access not answered in two states");
   a_gate_blocks_regs: assert property (
      reg_wr && !gate_q[ACCESS_ENABLE_BIT]
      && cpu_req.addr == MODE_CONTROL_ADDR |=> $stable(mode_q)) // RL18
      else $error("mode written while gated");
   a_rom_when_idle: assert property (
      mode_q[6:0] == 7'h00 |=> rom_read_en) // RL19
      else $error("rom read not enabled");
   a_erase_whole_block: assert property (
      block_erase != '0 |-> $past(mode_q[ERASE_GO_BIT])
      && block_erase == $past(select_q[ERASE_BLOCKS-1:0])) // RL2
      else $error("erase outside selected block");
   a_unit_aligned: assert property (
      unit_write |-> unit_base[UNIT_OFFSET_W-1:0] == '0) // RL1
      else $error("program unit misaligned");
   a_power_down_follow: assert property (
      subactive && !power_q[POWERDOWN_INHIBIT_BIT] |=> power_down) // RL14
      else $error("power-down not entered");

   c_erase_entry: cover property ($rose(mode_q[ERASE_GO_BIT]));
   c_program_entry: cover property ($rose(mode_q[PROGRAM_GO_BIT]));
   c_unit_write: cover property ($rose(unit_write));
   c_power_down: cover property ($rose(power_down));

endmodule : flash_ctrl

`default_nettype wire

//--- tb_flash_ctrl.sv
// Self-checking bench for the flash program/erase control block.
// Assumes the design package is compiled first; the bench drives the CPU bus
// itself at the falling edge and also runs a second copy built without flash.
`timescale 1ns/1ps
`default_nettype none

module tb_flash_ctrl import flash_ctrl_pkg::*; ;

   logic clock = 1'b0;
   logic resetn = 1'b0;
   cpu_req_s cpu_req = '0;
   logic subactive = 1'b0;
   logic fault_detect = 1'b0;
   logic cpu_ack, rom_read_en, power_down, unit_write, uw;
   logic [7:0] cpu_rdata, absent_rdata, rd, absent_rd, unit_data;
   logic [6:0] mode_bits, unit_offset;
   logic [4:0] block_erase;
   logic [14:0] unit_base;
   logic [2:0] access_block;
   int err_count = 0;
   int cmp_count = 0;
   // Block boundaries: address, expected unit base, offset and block index
   logic [15:0] blk_addr [5] = '{16'h03FF, 16'h0400, 16'h0BFF, 16'h0C00, 16'h7F80};
   logic [14:0] blk_base [5] = '{15'h0380, 15'h0400, 15'h0B80, 15'h0C00, 15'h7F80};
   logic [6:0] blk_off [5] = '{7'h7F, 7'h00, 7'h7F, 7'h00, 7'h00};

`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); \
      end \
   end

   always #2.5 clock = ~clock;

   flash_ctrl dut (.clock(clock), .resetn(resetn), .cpu_req(cpu_req), .subactive(subactive),
      .fault_detect(fault_detect), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
      .rom_read_en(rom_read_en), .mode_bits(mode_bits), .block_erase(block_erase),
      .power_down(power_down), .unit_write(unit_write), .unit_base(unit_base),
      .unit_offset(unit_offset), .unit_data(unit_data), .access_block(access_block));

   // Variant without flash shares the bus; only its read data is watched
   flash_ctrl #(.FLASH_FITTED(1'b0)) absent_dut (.clock(clock), .resetn(resetn),
      .cpu_req(cpu_req), .subactive(subactive), .fault_detect(fault_detect), .cpu_ack(),
      .cpu_rdata(absent_rdata), .rom_read_en(), .mode_bits(), .block_erase(),
      .power_down(), .unit_write(), .unit_base(), .unit_offset(), .unit_data(),
      .access_block());

   // ************************************************************
   // Bus tasks
   // ************************************************************
   // Request is held through the edge that samples the acknowledge, so the
   // held request is refused there and dropped at the next falling edge.
   task automatic acc(input logic w, input logic b, input logic [15:0] a,
         input logic [7:0] d);
      @(negedge clock);
      cpu_req = '{sel: 1'b1, wr: w, byte_acc: b, addr: a, wdata: d};
      @(posedge clock);
      @(negedge clock);
      `CHK(cpu_ack, 1'b1)
      rd = cpu_rdata;
      absent_rd = absent_rdata;
      uw = unit_write;
      @(posedge clock);
      @(negedge clock);
      `CHK(cpu_ack, 1'b0)
      cpu_req.sel = 1'b0;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      acc(1'b1, 1'b1, a, d);
   endtask

   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      acc(1'b0, 1'b1, a, 8'h00);
      `CHK(rd, e)
   endtask

   task give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (2) @(posedge clock);
      @(negedge clock);
      resetn = 1'b1;
      rdc(REGISTER_GATE_ADDR, 8'h00);
      `CHK(absent_rd, ABSENT_READ_VALUE)
      `CHK(rom_read_en, 1'b1)
      wr(MODE_CONTROL_ADDR, 8'h40);
      wr(REGISTER_GATE_ADDR, 8'h80);
      for (int i = 0; i < 4; i++) begin
         rdc(MODE_CONTROL_ADDR + 16'(i), 8'h00);
      end
      rdc(REGISTER_GATE_ADDR, 8'h80);
      wr(MODE_CONTROL_ADDR, 8'h3F);
      wr(ERASE_SELECT_ADDR, 8'h01);
      rdc(MODE_CONTROL_ADDR, 8'h00);
      rdc(ERASE_SELECT_ADDR, 8'h00);
      wr(MODE_CONTROL_ADDR, 8'hC0);
      rdc(MODE_CONTROL_ADDR, 8'h40);
      `CHK(absent_rd, ABSENT_READ_VALUE)
      `CHK(mode_bits, 7'h40)
      `CHK(rom_read_en, 1'b0)
      acc(1'b1, 1'b0, MODE_CONTROL_ADDR, 8'h60);
      rdc(MODE_CONTROL_ADDR, 8'h40);
      wr(FAULT_STATUS_ADDR, 8'h80);
      rdc(FAULT_STATUS_ADDR, 8'h00);
      rdc(16'hF024, 8'h00);
      wr(ERASE_SELECT_ADDR, 8'h03);
      rdc(ERASE_SELECT_ADDR, 8'h00);
      wr(ERASE_SELECT_ADDR, 8'h10);
      rdc(ERASE_SELECT_ADDR, 8'h10);
      wr(MODE_CONTROL_ADDR, 8'h42);
      rdc(MODE_CONTROL_ADDR, 8'h40);
      wr(MODE_CONTROL_ADDR, 8'h60);
      wr(MODE_CONTROL_ADDR, 8'h62);
      rdc(MODE_CONTROL_ADDR, 8'h62);
      `CHK(block_erase, 5'h10)
      wr(MODE_CONTROL_ADDR, 8'h40);
      `CHK(block_erase, 5'h00)
      wr(MODE_CONTROL_ADDR, 8'h41);
      rdc(MODE_CONTROL_ADDR, 8'h40);
      wr(MODE_CONTROL_ADDR, 8'h50);
      wr(MODE_CONTROL_ADDR, 8'h51);
      rdc(MODE_CONTROL_ADDR, 8'h51);
      `CHK(mode_bits, 7'h51)
      wr(16'h1234, 8'h5A);
      `CHK(uw, 1'b1)
      `CHK(unit_base, 15'h1200)
      `CHK(unit_offset, 7'h34)
      `CHK(unit_data, 8'h5A)
      for (int i = 0; i < 5; i++) begin
         wr(blk_addr[i], 8'(i));
         `CHK(unit_base, blk_base[i])
         `CHK(unit_offset, blk_off[i])
         `CHK(access_block, 3'(i))
      end
      wr(MODE_CONTROL_ADDR, 8'h40);
      wr(16'h0100, 8'h00);
      `CHK(uw, 1'b0)
      wr(MODE_CONTROL_ADDR, 8'h00);
      rdc(ERASE_SELECT_ADDR, 8'h00);
      `CHK(rom_read_en, 1'b1)
      subactive = 1'b1;
      rdc(POWER_CONTROL_ADDR, 8'h00);
      `CHK(power_down, 1'b1)
      wr(POWER_CONTROL_ADDR, 8'h80);
      rdc(POWER_CONTROL_ADDR, 8'h80);
      `CHK(power_down, 1'b0)
      subactive = 1'b0;
      // Fault during erase stops the block erase and stays until reset
      wr(MODE_CONTROL_ADDR, 8'h40);
      wr(ERASE_SELECT_ADDR, 8'h01);
      wr(MODE_CONTROL_ADDR, 8'h60);
      wr(MODE_CONTROL_ADDR, 8'h62);
      `CHK(block_erase, 5'h01)
      fault_detect = 1'b1;
      @(negedge clock);
      fault_detect = 1'b0;
      rdc(FAULT_STATUS_ADDR, 8'h80);
      `CHK(block_erase, 5'h00)
      wr(REGISTER_GATE_ADDR, 8'h00);
      rdc(MODE_CONTROL_ADDR, 8'h00);
      give_verdict;
   end

   // About 165 cycles of traffic are expected; the limit leaves wide margin
   initial begin
      #20000;
      err_count++;
      give_verdict;
   end

endmodule // tb_flash_ctrl

`default_nettype wire
